// ===== core/eosc_pkg.sv
// Constants for the external oscillator and clock source control block.
// Assumes a single 25 MHz bus clock and an AHB-Lite master.
package eosc_pkg;
    // =====================================================
    // Register map (printed offsets are not word multiples)
    localparam logic [7:0] EOSC_IDX_EXT_CTRL = 8'hb1;
    localparam logic [7:0] EOSC_IDX_CLK_SEL = 8'ha9;
    localparam logic [7:0] EOSC_IDX_INT_CTRL = 8'hb2;
    localparam logic [7:0] EOSC_IDX_IRQ_STAT = 8'hc0;
    localparam logic [7:0] EOSC_IDX_IRQ_MASK = 8'hc1;
    localparam logic [7:0] EOSC_IDX_SETTLE = 8'hc2;
    localparam int EOSC_ADDR_W = 10;

    // =====================================================
    // Field positions and reset values
    localparam int EOSC_VLD_BIT = 7;
    localparam int EOSC_MODE_LSB = 4;
    localparam int EOSC_FREQ_LSB = 0;
    localparam int EOSC_IOSC_EN_BIT = 7;
    localparam int EOSC_IOSC_RDY_BIT = 6;
    localparam logic [7:0] EOSC_EXT_CTRL_RST = 8'h00;
    localparam logic [7:0] EOSC_CLK_SEL_RST = 8'h00;
    localparam logic [7:0] EOSC_INT_CTRL_RST = 8'h00;
    localparam logic [1:0] EOSC_SRC_EXT = 2'h1;
    localparam logic [1:0] EOSC_SRC_INT = 2'h0;

    // Interrupt status bits
    localparam int EOSC_EV_VALID = 0;
    localparam int EOSC_EV_LOST = 1;
    localparam int EOSC_EV_SWITCH = 2;

    // =====================================================
    // Timing: default crystal settle time after enable
    localparam int EOSC_CLK_MHZ = 25;
    localparam int EOSC_SETTLE_US = 1000;
    localparam int EOSC_SETTLE_CYC = EOSC_SETTLE_US * EOSC_CLK_MHZ;
    localparam int EOSC_CNT_W = 16;

    typedef enum logic [2:0] {
        EOSC_MODE_OFF0, EOSC_MODE_OFF1, EOSC_MODE_CMOS, EOSC_MODE_CMOS_DIV2,
        EOSC_MODE_RC, EOSC_MODE_CAP, EOSC_MODE_XTAL, EOSC_MODE_XTAL_DIV2
    } eosc_mode_t;
endpackage

// ===== core/eosc_settle.sv
// Crystal settle timer: counts stable external clock activity.
// Assumes osc_active is already synchronous to mclk.
module eosc_settle
    import eosc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // Control
    input wire logic start,
    input wire logic need_settle,
    input wire logic osc_active,
    input wire logic [EOSC_CNT_W-1:0] settle_cycles,
    // Status
    output logic settled
);
    logic [EOSC_CNT_W-1:0] count;

    // =====================================================
    // Counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= '0;
            settled <= 1'b0;
        end else if (clk_en) begin
            if (!start || !osc_active) begin
                // Losing activity restarts the wait
                count <= '0;
                settled <= 1'b0;
            end else if (!need_settle) begin
                settled <= 1'b1;
            end else if (count >= settle_cycles) begin
                settled <= 1'b1;
            end else begin
                count <= count + 1'b1;
            end
        end
    end
endmodule

// ===== core/eosc_ctrl.sv
// External oscillator control, clock source select and status registers.
// Assumes an AHB-Lite master on mclk; osc_active comes from the analog
// amplitude detector, asynchronous to mclk.
//
// Contract
// - Hardware sets the crystal-valid flag once the oscillator settles.
// - Only source field value 01b runs the system clock from the external one.
// - The external clock stays available to peripherals when internal is used.
// - Switching sources is glitch free when the new source is ready.
// - The internal oscillator is usable right after its enable write.
// - RC and capacitor modes need no settling wait.
//
// Implementation choice: register access over AHB-Lite.
module eosc_ctrl
    import eosc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Oscillator analog side
    input wire logic osc_active,
    output logic osc_enable,
    output logic [2:0] osc_mode,
    output logic [2:0] osc_freq,
    output logic osc_div2,
    output logic int_osc_enable,
    // Clock steering
    output logic [1:0] sysclk_select,
    output logic periph_ext_clk_en,
    // Interrupt
    output logic irq
);
    import eosc_pkg::*;

    logic [2:0] ext_osc_mode_field;
    logic [2:0] ext_osc_freq_ctrl;
    logic [1:0] sysclk_source_field;
    logic int_en;
    logic int_rdy;
    logic crystal_valid_flag;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [EOSC_CNT_W-1:0] settle_cycles;
    logic act_s1;
    logic act_s2;
    logic settled;
    logic valid_q;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_idx;
    logic addr_ok;
    logic [7:0] a_idx;
    logic osc_on;
    logic need_settle;
    logic [2:0] events;
    logic wr_en;
    logic rd_stat;
    logic [7:0] rd_byte;
    logic [1:0] next_sel;

    assign a_idx = haddr[EOSC_ADDR_W-1:2];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // =====================================================
    // Mode decode
    // mode decode
    assign osc_on = ext_osc_mode_field[2:1] != 2'h0;
    assign need_settle = eosc_mode_t'(ext_osc_mode_field) == EOSC_MODE_XTAL
        || eosc_mode_t'(ext_osc_mode_field) == EOSC_MODE_XTAL_DIV2;
    assign osc_div2 = ext_osc_mode_field[0] && (ext_osc_mode_field[2]
        ? ext_osc_mode_field[1] : ext_osc_mode_field[1]);
    assign osc_enable = osc_on;
    assign osc_mode = ext_osc_mode_field;
    assign osc_freq = ext_osc_freq_ctrl;
    assign int_osc_enable = int_en;
    assign periph_ext_clk_en = osc_on && crystal_valid_flag;
    assign sysclk_select = sysclk_source_field;

    // =====================================================
    // Detector synchroniser
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            act_s1 <= 1'b0;
            act_s2 <= 1'b0;
        end else if (clk_en) begin
            act_s1 <= osc_active;
            act_s2 <= act_s1;
        end
    end

    eosc_settle u_settle (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .start(osc_on),
        .need_settle(need_settle),
        .osc_active(act_s2),
        .settle_cycles(settle_cycles),
        .settled(settled)
    );

    assign crystal_valid_flag = settled;

    // =====================================================
    // AHB address phase capture
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_idx <= 8'h00;
        end else if (clk_en && hready) begin
            ph_valid <= hsel && htrans[1];
            ph_write <= hwrite;
            ph_idx <= a_idx;
        end
    end

    assign wr_en = clk_en && ph_valid && ph_write;
    assign rd_stat = clk_en && hready && hsel && htrans[1] && !hwrite
        && a_idx == EOSC_IDX_IRQ_STAT;

    // Internal oscillator ready one cycle after enable
    // immediate use
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            int_rdy <= 1'b0;
        end else if (clk_en) begin
            int_rdy <= int_en;
        end
    end

    // =====================================================
    // Register writes
    // field layout
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_osc_mode_field <= EOSC_EXT_CTRL_RST[6:4];
            ext_osc_freq_ctrl <= EOSC_EXT_CTRL_RST[2:0];
            int_en <= EOSC_INT_CTRL_RST[EOSC_IOSC_EN_BIT];
            irq_mask <= 3'h0;
            settle_cycles <= EOSC_CNT_W'(EOSC_SETTLE_CYC);
        end else if (wr_en) begin
            unique case (ph_idx)
                EOSC_IDX_EXT_CTRL: begin
                    ext_osc_mode_field <= hwdata[EOSC_MODE_LSB +: 3];
                    ext_osc_freq_ctrl <= hwdata[EOSC_FREQ_LSB +: 3];
                end
                EOSC_IDX_INT_CTRL: int_en <= hwdata[EOSC_IOSC_EN_BIT];
                EOSC_IDX_IRQ_MASK: irq_mask <= hwdata[2:0];
                EOSC_IDX_SETTLE: settle_cycles <= hwdata[EOSC_CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // =====================================================
    // Clock source select; a written switch is taken only to a ready source, the fallback to internal is taken unconditionally
    always_comb begin
        next_sel = sysclk_source_field;
        if (wr_en && ph_idx == EOSC_IDX_CLK_SEL) begin
            if (hwdata[1:0] == EOSC_SRC_EXT) begin
                if (crystal_valid_flag) begin
                    next_sel = EOSC_SRC_EXT;
                end
            end else if (int_en || int_rdy) begin
                next_sel = hwdata[1:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sysclk_source_field <= EOSC_CLK_SEL_RST[1:0];
        end else if (clk_en) begin
            // Fall back to internal if the external source dies
            if (sysclk_source_field == EOSC_SRC_EXT && !crystal_valid_flag) begin
                sysclk_source_field <= EOSC_SRC_INT;
            end else begin
                sysclk_source_field <= next_sel;
            end
        end
    end

    // =====================================================
    // Interrupt status; set wins over read clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            valid_q <= 1'b0;
        end else if (clk_en) begin
            valid_q <= crystal_valid_flag;
        end
    end

    assign events[EOSC_EV_VALID] = crystal_valid_flag && !valid_q;
    assign events[EOSC_EV_LOST] = !crystal_valid_flag && valid_q;
    assign events[EOSC_EV_SWITCH] = next_sel != sysclk_source_field;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status <= 3'h0;
        end else if (clk_en) begin
            irq_status <= (rd_stat ? 3'h0 : irq_status) | events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // =====================================================
    // Read data
    always_comb begin
        rd_byte = 8'h00;
        unique case (a_idx)
            EOSC_IDX_EXT_CTRL: rd_byte = {crystal_valid_flag,
                ext_osc_mode_field, 1'b0, ext_osc_freq_ctrl};
            EOSC_IDX_CLK_SEL: rd_byte = {6'h00, sysclk_source_field};
            EOSC_IDX_INT_CTRL: rd_byte = {int_en, int_rdy, 6'h00};
            EOSC_IDX_IRQ_STAT: rd_byte = {5'h00, irq_status};
            EOSC_IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
            if (a_idx == EOSC_IDX_SETTLE) begin
                hrdata <= {16'h0000, settle_cycles};
            end else begin
                hrdata <= {24'h000000, rd_byte};
            end
        end
    end
endmodule

// ===== dv/eosc_osc_model.sv
// Far-side oscillator: crystal, RC, capacitor or CMOS clock source.
// Assumes the bench clock; stop models an oscillator that dies.
module eosc_osc_model #(parameter int XTAL_DLY = 20) (
    // Clock
    input wire logic mclk,
    // Drive circuit
    input wire logic osc_enable,
    input wire logic [2:0] osc_mode,
    input wire logic stop,
    // Amplitude detector
    output logic osc_active
);
    int cnt = 0;
    // ==========
    // Start-up
    // only a crystal needs a start-up time
    assign osc_active = osc_enable && !stop &&
        (osc_mode[2:1] != 2'h3 || cnt >= XTAL_DLY);
    always @(posedge mclk) begin
        cnt <= osc_enable ? cnt + 1 : 0;
    end
endmodule

// ===== dv/eosc_ctrl_props.sv
// Port checker for the oscillator control block.
// Assumes one clock domain and is bound to eosc_ctrl.
module eosc_ctrl_props
    import eosc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Watched outputs and detector input
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic osc_active,
    input wire logic osc_enable,
    input wire logic [2:0] osc_mode,
    input wire logic osc_div2,
    input wire logic [1:0] sysclk_select,
    input wire logic periph_ext_clk_en,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========
    // Properties
    osc_off_a: assert property (osc_enable == (osc_mode[2:1] != 2'h0))
        else $error("enable disagrees with mode");
    div_two_a: assert property (osc_div2 == (osc_mode[1:0] == 2'h3))
        else $error("divider disagrees with mode");
    ext_switch_a: assert property (
        $rose(sysclk_select == EOSC_SRC_EXT) |-> periph_ext_clk_en)
        else $error("external source taken while not valid");
    periph_on_a: assert property (periph_ext_clk_en |-> osc_enable)
        else $error("peripheral clock with oscillator off");
    valid_rise_a: assert property (
        $rose(periph_ext_clk_en) |-> $past(osc_active, 2))
        else $error("valid without detector activity");
    valid_drop_a: assert property (
        !osc_active [*6] |=> !periph_ext_clk_en)
        else $error("valid kept after oscillator stopped");
    ext_fallback_a: assert property (
        sysclk_select == EOSC_SRC_EXT && !periph_ext_clk_en
        |-> ##[1:2] sysclk_select == EOSC_SRC_INT)
        else $error("external source kept after loss");
    zero_wait_a: assert property (hreadyout)
        else $error("slave inserted wait state");
    okay_resp_a: assert property (!hresp)
        else $error("error response");
    cover property ($rose(irq));
    cover property ($rose(periph_ext_clk_en));
    cover property ($fell(sysclk_select == EOSC_SRC_EXT));
endmodule
bind eosc_ctrl eosc_ctrl_props chk (.mclk(mclk), .rst(rst),
    .hreadyout(hreadyout), .hresp(hresp), .osc_active(osc_active),
    .osc_enable(osc_enable), .osc_mode(osc_mode), .osc_div2(osc_div2),
    .sysclk_select(sysclk_select), .periph_ext_clk_en(periph_ext_clk_en),
    .irq(irq));

// ===== dv/ext_osc_and_sysclk_select_bench.sv
// Self-checking bench for eosc_ctrl with an oscillator model.
// Assumes settle count shortened to 10 cycles by a register write.
module ext_osc_and_sysclk_select_bench import eosc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] A_EXT = {EOSC_IDX_EXT_CTRL, 2'b00};
    localparam logic [9:0] A_SEL = {EOSC_IDX_CLK_SEL, 2'b00};
    localparam logic [9:0] A_INT = {EOSC_IDX_INT_CTRL, 2'b00};
    localparam logic [9:0] A_ST = {EOSC_IDX_IRQ_STAT, 2'b00};
    localparam logic [9:0] A_MSK = {EOSC_IDX_IRQ_MASK, 2'b00};
    localparam logic [9:0] A_SET = {EOSC_IDX_SETTLE, 2'b00};
    logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, stop = 0, rd_dp = 0;
    logic clk_en = 1;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'h0282;
    logic hreadyout, hresp, osc_active, osc_enable, osc_div2, irq;
    logic int_osc_enable, periph_ext_clk_en;
    logic [2:0] osc_mode, osc_freq;
    logic [1:0] sysclk_select;
    logic [7:0] q[$];
    int err_count = 0, checks = 0;
    initial forever #20 mclk = ~mclk;
    eosc_ctrl uut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .osc_active(osc_active),
        .osc_enable(osc_enable), .osc_mode(osc_mode), .osc_freq(osc_freq),
        .osc_div2(osc_div2), .int_osc_enable(int_osc_enable),
        .sysclk_select(sysclk_select), .periph_ext_clk_en(periph_ext_clk_en),
        .irq(irq));
    eosc_osc_model osc (.mclk(mclk), .osc_enable(osc_enable),
        .osc_mode(osc_mode), .stop(stop), .osc_active(osc_active));
    // ==========
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [31:0] v, input logic [31:0] e, input string m);
        checks++;
        if (v !== e) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task bus(input logic [9:0] a, input logic w, input logic [7:0] d);
        @(posedge mclk);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {22'h0, a};
        hwrite <= w;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= {24'h0, d};
        rd_dp <= !w;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd_dp <= 0;
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task rd(input logic [9:0] a, input logic [7:0] e);
        q.push_back(e);
        bus(a, 1'b0, 8'h00);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Read data compared against the oldest note
    always @(posedge mclk) begin
        if (rd_dp) chk(hrdata, {24'h0, q.pop_front()}, "read data");
    end
    initial begin
        repeat (3000) @(posedge mclk);
        err_count++;
        final_report;
    end
    // ==========
    // Tests
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 0;
        wr(A_SET, 8'd10);
        rd(A_EXT, 8'h00);
        rd(A_SEL, 8'h00);
        wr(10'h3fc, 8'hff);
        rd(10'h3fc, 8'h00);
        $display("reset test done");
        for (int m = 0; m < 6; m++) begin
            seed = lfsr(seed);
            wr(A_EXT, {1'b1, m[2:0], 1'b1, seed[2:0]});
            repeat (8) @(posedge mclk);
            chk({29'h0, osc_freq}, {29'h0, seed[2:0]}, "freq field");
            rd(A_EXT, {m >= 2, m[2:0], 1'b0, seed[2:0]});
        end
        wr(A_EXT, 8'h00);
        repeat (8) @(posedge mclk);
        rd(A_ST, 8'h03);
        rd(A_ST, 8'h00);
        $display("mode test done");
        wr(A_MSK, 8'h07);
        seed = lfsr(seed);
        wr(A_EXT, {4'h6, 1'b0, seed[2:0]});
        rd(A_EXT, {4'h6, 1'b0, seed[2:0]});
        wr(A_SEL, 8'h01);
        rd(A_SEL, 8'h00);
        repeat (50) @(posedge mclk);
        rd(A_EXT, {4'he, 1'b0, seed[2:0]});
        chk({31'h0, periph_ext_clk_en}, 1, "peripheral clock");
        chk({31'h0, irq}, 1, "valid interrupt");
        rd(A_ST, 8'h01);
        @(negedge mclk);
        chk({31'h0, irq}, 0, "interrupt after clear");
        wr(A_EXT, 8'h60);
        rd(A_EXT, 8'he0);
        wr(A_SEL, 8'h01);
        rd(A_SEL, 8'h01);
        rd(A_ST, 8'h04);
        $display("crystal test done");
        wr(A_MSK, 8'h00);
        stop <= 1;
        repeat (10) @(negedge mclk);
        chk({31'h0, irq}, 0, "masked loss");
        rd(A_SEL, 8'h00);
        wr(A_MSK, 8'h02);
        repeat (2) @(negedge mclk);
        chk({31'h0, irq}, 1, "unmasked loss");
        wr(A_INT, 8'h80);
        @(negedge mclk);
        chk({31'h0, int_osc_enable}, 1, "internal enable");
        wr(A_SEL, 8'h00);
        rd(A_SEL, 8'h00);
        // Frozen clock enable must hold the valid flag low
        clk_en <= 0;
        stop <= 0;
        repeat (20) @(negedge mclk);
        chk({31'h0, periph_ext_clk_en}, 0, "frozen valid");
        @(posedge mclk);
        clk_en <= 1;
        repeat (20) @(negedge mclk);
        chk({31'h0, periph_ext_clk_en}, 1, "resumed valid");
        $display("loss test done");
        final_report;
    end
endmodule
